// >>> src/asx_pkg.sv
// Package for the subtract / xor / swap execution datapath.
// Assumes a single 100 MHz core clock and an APB register slave.
package asx_pkg;
  // ****************************************
  // Operation codes
  // ****************************************
  typedef enum logic [3:0] {
    ASX_OP_NONE = 4'h0,
    ASX_OP_LIT_MINUS_ACC = 4'h1,
    ASX_OP_FILE_MINUS_ACC = 4'h2,
    ASX_OP_FILE_MINUS_ACC_BORROW = 4'h3,
    ASX_OP_NIBBLE_EXCHANGE = 4'h4,
    ASX_OP_PORT_DIR_LOAD = 4'h5,
    ASX_OP_ACC_XOR_LIT = 4'h6,
    ASX_OP_ACC_XOR_FILE = 4'h7,
    ASX_OP_SLEEP = 4'h8
  } asx_op_t;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ASX_OFF_ACC = 8'h00;
  localparam logic [7:0] ASX_OFF_STATUS = 8'h04;
  localparam logic [7:0] ASX_OFF_INSTR = 8'h08;
  localparam logic [7:0] ASX_OFF_PORT_A_DIR = 8'h0C;
  localparam logic [7:0] ASX_OFF_PORT_B_DIR = 8'h10;
  localparam logic [7:0] ASX_OFF_PORT_C_DIR = 8'h14;
  localparam logic [7:0] ASX_OFF_WDOG = 8'h18;
  localparam logic [7:0] ASX_OFF_FILE_BASE = 8'h80;

  // ****************************************
  // Status bit positions and instruction fields
  // ****************************************
  localparam int ASX_ST_CARRY = 0;
  localparam int ASX_ST_NIBBLE = 1;
  localparam int ASX_ST_ZERO = 2;
  localparam int ASX_ST_PWRDN = 3;
  localparam int ASX_ST_TMOUT = 4;
  localparam int ASX_ST_SLEEP = 5;
  localparam int ASX_IN_OP_LSB = 16;
  localparam int ASX_IN_DEST = 15;
  localparam int ASX_IN_FADDR_LSB = 8;

  // ****************************************
  // Reset values and limits
  // ****************************************
  localparam logic [7:0] ASX_RST_ACC = 8'h00;
  localparam logic [7:0] ASX_RST_DIR = 8'hFF;
  localparam logic [4:0] ASX_RST_STATUS = 5'h18;
  localparam logic [2:0] ASX_DIR_FIRST = 3'h5;
  localparam logic [7:0] ASX_WDOG_CLEAR = 8'h00;
endpackage

// >>> src/asx_core.sv
// Execution datapath for subtract, xor, nibble swap, port direction and sleep.
// Assumes APB master on the core clock; wake from sleep is via reset only.
// ****************************************
// Datapath module
// ****************************************
//
// The APB register port and the placing of the registers were left to the implementer.
module asx_core
  import asx_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Watchdog and oscillator control
  input wire logic wdog_tick_in,
  output logic wdog_clear_out,
  output logic osc_stop_out,
  // Port direction registers
  output logic [7:0] port_a_dir_out,
  output logic [7:0] port_b_dir_out,
  output logic [7:0] port_c_dir_out
);
  // ****************************************
  // State
  // ****************************************
  logic [7:0] acc; // Accumulator
  logic [7:0] file_mem [128]; // File registers
  logic [4:0] status; // Timeout, power-down, Z, DC, C
  logic sleeping; // Halted, oscillator stopped
  logic [7:0] wdog; // Watchdog counter
  logic [7:0] wdog_pre; // Watchdog prescaler
  logic [7:0] dir_a, dir_b, dir_c; // Port direction registers
  logic wdog_clr_q; // Registered clear pulse

  logic [7:0] next_acc;
  logic [4:0] next_status;
  logic next_sleeping;
  logic [7:0] next_wdog, next_wdog_pre;
  logic [7:0] next_dir_a, next_dir_b, next_dir_c;
  logic next_wdog_clr;
  logic file_we; // File writeback strobe
  logic [6:0] file_wa; // File writeback address
  logic [7:0] file_wd; // File writeback data

  // ****************************************
  // Bus decode
  // ****************************************
  logic wr_acc, wr_exec, wr_file, rd_hit;
  asx_op_t op;
  logic dest;
  logic [6:0] faddr;
  logic [7:0] lit;
  logic [7:0] fval;

  // Single-cycle access phase; every address answers in the same cycle
  assign pready_out = 1'b1;
  assign wr_acc = psel_in && penable_in && pwrite_in && paddr_in == ASX_OFF_ACC;
  assign wr_exec = psel_in && penable_in && pwrite_in && paddr_in == ASX_OFF_INSTR
                   && !sleeping;
  assign wr_file = psel_in && penable_in && pwrite_in && paddr_in[7];
  assign op = asx_op_t'(pwdata_in[ASX_IN_OP_LSB +: 4]);
  assign dest = pwdata_in[ASX_IN_DEST];
  assign faddr = pwdata_in[ASX_IN_FADDR_LSB +: 7];
  assign lit = pwdata_in[7:0];
  assign fval = file_mem[faddr];

  // Decode a readable offset
  function automatic logic known(input logic [7:0] a);
    known = a[7] || a == ASX_OFF_ACC || a == ASX_OFF_STATUS || a == ASX_OFF_INSTR
            || a == ASX_OFF_PORT_A_DIR || a == ASX_OFF_PORT_B_DIR
            || a == ASX_OFF_PORT_C_DIR || a == ASX_OFF_WDOG;
  endfunction
  assign rd_hit = known(paddr_in);
  assign pslverr_out = psel_in && penable_in && !rd_hit;

  // Subtract with borrow in; returns {carry, nibble carry, result}
  function automatic logic [9:0] sub8(input logic [7:0] m, input logic [7:0] s,
                                      input logic bin);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, m} - {1'b0, s} - {8'h00, bin};
    low = {1'b0, m[3:0]} - {1'b0, s[3:0]} - {4'h0, bin};
    sub8 = {~full[8], ~low[4], full[7:0]};
  endfunction

  // ****************************************
  // Execute: next values
  // ****************************************
  always_comb begin
    logic [9:0] r;
    logic [7:0] res;
    logic flags_cz, flag_z;
    r = 10'h000;
    res = 8'h00;
    flags_cz = 1'b0;
    flag_z = 1'b0;
    next_acc = acc;
    next_status = status;
    next_sleeping = sleeping;
    next_dir_a = dir_a;
    next_dir_b = dir_b;
    next_dir_c = dir_c;
    next_wdog_clr = 1'b0;
    file_we = 1'b0;
    file_wa = faddr;
    file_wd = 8'h00;
    // Watchdog runs while awake or asleep, from its tick enable
    next_wdog_pre = wdog_pre + (wdog_tick_in ? 8'h01 : 8'h00);
    next_wdog = wdog + ((wdog_tick_in && wdog_pre == 8'hFF) ? 8'h01 : 8'h00);
    if (wr_acc) begin
      next_acc = pwdata_in[7:0];
    end
    if (wr_file) begin
      file_we = 1'b1;
      file_wa = paddr_in[6:0];
      file_wd = pwdata_in[7:0];
    end
    // One write executes the whole instruction in one cycle
    if (wr_exec) begin
      case (op)
        ASX_OP_LIT_MINUS_ACC: begin
          r = sub8(lit, acc, 1'b0);
          next_acc = r[7:0];
          flags_cz = 1'b1;
        end
        ASX_OP_FILE_MINUS_ACC: begin
          r = sub8(fval, acc, 1'b0);
          res = r[7:0];
          flags_cz = 1'b1;
        end
        ASX_OP_FILE_MINUS_ACC_BORROW: begin
          r = sub8(fval, acc, ~status[ASX_ST_CARRY]);
          res = r[7:0];
          flags_cz = 1'b1;
        end
        ASX_OP_NIBBLE_EXCHANGE: begin
          res = {fval[3:0], fval[7:4]};
        end
        ASX_OP_ACC_XOR_FILE: begin
          res = acc ^ fval;
          flag_z = 1'b1;
        end
        ASX_OP_ACC_XOR_LIT: begin
          next_acc = acc ^ lit;
          flag_z = 1'b1;
          r[7:0] = next_acc;
        end
        ASX_OP_PORT_DIR_LOAD: begin
          // Out-of-range operands do nothing
          // Whole literal is compared so 8'h0D and the like stay ignored
          case (lit - {5'h00, ASX_DIR_FIRST})
            8'h00: next_dir_a = acc;
            8'h01: next_dir_b = acc;
            8'h02: next_dir_c = acc;
            default: next_dir_a = dir_a;
          endcase
        end
        ASX_OP_SLEEP: begin
          next_wdog = ASX_WDOG_CLEAR;
          next_wdog_pre = 8'h00;
          next_wdog_clr = 1'b1;
          next_sleeping = 1'b1;
          next_status[ASX_ST_PWRDN] = 1'b0;
          next_status[ASX_ST_TMOUT] = 1'b1;
        end
        default: next_acc = acc;
      endcase
      // File-source results follow the destination bit
      if (op == ASX_OP_FILE_MINUS_ACC || op == ASX_OP_FILE_MINUS_ACC_BORROW
          || op == ASX_OP_NIBBLE_EXCHANGE || op == ASX_OP_ACC_XOR_FILE) begin
        if (dest) begin
          file_we = 1'b1;
          file_wa = faddr;
          file_wd = res;
        end else begin
          next_acc = res;
        end
        r[7:0] = res;
      end
      if (flags_cz) begin
        next_status[ASX_ST_CARRY] = r[9];
        next_status[ASX_ST_NIBBLE] = r[8];
      end
      if (flags_cz || flag_z) begin
        next_status[ASX_ST_ZERO] = (r[7:0] == 8'h00);
      end
    end
  end

  // ****************************************
  // Register update
  // ****************************************
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc <= ASX_RST_ACC;
      status <= ASX_RST_STATUS;
      sleeping <= 1'b0;
      wdog <= ASX_WDOG_CLEAR;
      wdog_pre <= 8'h00;
      dir_a <= ASX_RST_DIR;
      dir_b <= ASX_RST_DIR;
      dir_c <= ASX_RST_DIR;
      wdog_clr_q <= 1'b0;
    end else begin
      acc <= next_acc;
      status <= next_status;
      sleeping <= next_sleeping;
      wdog <= next_wdog;
      wdog_pre <= next_wdog_pre;
      dir_a <= next_dir_a;
      dir_b <= next_dir_b;
      dir_c <= next_dir_c;
      wdog_clr_q <= next_wdog_clr;
    end
  end

  // File memory has no reset; software must initialise it
  always_ff @(posedge core_clk_in) begin
    if (file_we) begin
      file_mem[file_wa] <= file_wd;
    end
  end

  // ****************************************
  // Read mux and outputs
  // ****************************************
  always_comb begin
    prdata_out = 32'h0000_0000;
    case (paddr_in)
      ASX_OFF_ACC: prdata_out[7:0] = acc;
      ASX_OFF_STATUS: prdata_out[5:0] = {sleeping, status};
      ASX_OFF_PORT_A_DIR: prdata_out[7:0] = dir_a;
      ASX_OFF_PORT_B_DIR: prdata_out[7:0] = dir_b;
      ASX_OFF_PORT_C_DIR: prdata_out[7:0] = dir_c;
      ASX_OFF_WDOG: prdata_out[7:0] = wdog;
      default: prdata_out[7:0] = paddr_in[7] ? file_mem[paddr_in[6:0]] : 8'h00;
    endcase
  end
  assign wdog_clear_out = wdog_clr_q;
  assign osc_stop_out = sleeping;
  assign port_a_dir_out = dir_a;
  assign port_b_dir_out = dir_b;
  assign port_c_dir_out = dir_c;

  // ****************************************
  // Assertions
  // ****************************************
  logic [7:0] lit_d, acc_d; // Operands one cycle back, for the checks
  sequence s_exec(asx_op_t o);
    wr_exec && op == o;
  endsequence
  property p_lit_sub;
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_exec(ASX_OP_LIT_MINUS_ACC) |=> acc == 8'(lit_d - acc_d);
  endproperty
  always_ff @(posedge core_clk_in) begin
    lit_d <= lit;
    acc_d <= acc;
  end
  a_lit_sub: assert property (p_lit_sub) else $error("literal subtract wrong");
  property p_carry;
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_exec(ASX_OP_LIT_MINUS_ACC) |=> status[ASX_ST_CARRY] == (acc_d <= lit_d)
      && status[ASX_ST_NIBBLE] == (acc_d[3:0] <= lit_d[3:0]);
  endproperty
  a_carry: assert property (p_carry) else $error("borrow flags wrong");
  property p_sleep;
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_exec(ASX_OP_SLEEP) |=> wdog == 8'h00 && osc_stop_out && wdog_clear_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
  property p_sleep_flags;
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_exec(ASX_OP_SLEEP) |=> !status[ASX_ST_PWRDN] && status[ASX_ST_TMOUT]
      && status[2:0] == $past(status[2:0]);
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");
  property p_dest_acc;
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_exec(ASX_OP_NIBBLE_EXCHANGE) && !dest |=> acc == {$past(fval[3:0]), $past(fval[7:4])}
      && status == $past(status);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("swap to acc wrong");
  property p_dir;
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_exec(ASX_OP_PORT_DIR_LOAD) && lit == 8'h06 |=> dir_b == acc_d
      && status == $past(status);
  endproperty
  a_dir: assert property (p_dir) else $error("direction load wrong");
  property p_xor_lit;
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_exec(ASX_OP_ACC_XOR_LIT) |=> acc == (acc_d ^ lit_d)
      && status[ASX_ST_ZERO] == (acc == 8'h00) && status[1:0] == $past(status[1:0]);
  endproperty
  a_xor_lit: assert property (p_xor_lit) else $error("xor literal wrong");
  property p_xor_file;
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_exec(ASX_OP_ACC_XOR_FILE) && dest |-> file_we && file_wd == (acc ^ fval)
      && next_acc == acc;
  endproperty
  a_xor_file: assert property (p_xor_file) else $error("xor file wrong");
endmodule

// >>> test/alu_subtract_xor_swap_ops_tb.sv
// Self-checking bench for the subtract / xor / swap / sleep datapath.
// Assumes asx_pkg and asx_core are compiled first; APB is the only way in.
module alu_subtract_xor_swap_ops_tb
  import asx_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals and model state
  // ****************************************
  logic clk;
  logic resetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wdog_tick;
  logic wdog_clear;
  logic osc_stop;
  logic [7:0] dir_a;
  logic [7:0] dir_b;
  logic [7:0] dir_c;
  int n_errors = 0;
  int total_checks = 0;
  int n_clear = 0; // Watchdog clear pulses seen
  int i;
  logic [3:0] op;
  logic [7:0] m_acc; // Expected accumulator
  logic [7:0] m_f; // Expected file register
  logic m_c = 1'b0;
  logic m_dc = 1'b0;
  logic m_z = 1'b0;
  logic [7:0] m_dir [3] = '{8'hFF, 8'hFF, 8'hFF};
  // ****************************************
  // Device, clock and monitors
  // ****************************************
  asx_core asx_core_i (
    .core_clk_in(clk), .resetn_in(resetn), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .wdog_tick_in(wdog_tick),
    .wdog_clear_out(wdog_clear), .osc_stop_out(osc_stop), .port_a_dir_out(dir_a),
    .port_b_dir_out(dir_b), .port_c_dir_out(dir_c));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Random prescaler ticks keep the watchdog moving
  always @(posedge clk) begin
    wdog_tick <= 1'($urandom_range(1));
  end
  // Count clear pulses; a single one is expected per sleep
  // Sampled mid-cycle, where the registered pulse has settled
  always @(negedge clk) begin
    if (wdog_clear === 1'b1) n_clear++;
  end
  // ****************************************
  // Tasks and expectation functions
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; bounded wait on pready, idle edge after release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    logic rdy;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Answer is taken as it stands just before the completing edge
    do begin
      @(negedge clk);
      rdy = (pready === 1'b1);
      rd = prdata;
      err = pslverr;
      @(posedge clk);
      n++;
    end while (!rdy && n < 50);
    if (!rdy) begin
      n_errors++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask
  // Returns {carry, nibble carry, result}; carry high means no borrow
  function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                      input logic br);
    logic [8:0] r;
    logic [4:0] n;
    r = {1'b0, a} - {1'b0, b} - 9'(br);
    n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(br);
    return {~r[8], ~n[4], r[7:0]};
  endfunction
  // Load operands, execute one instruction, then read back acc, file register and status and check the direction ports
  task automatic do_op(input logic [3:0] o, input logic d, input logic [6:0] fa,
                       input logic [7:0] lit, input logic [7:0] acc, input logic [7:0] fv);
    logic [9:0] s;
    logic [7:0] res;
    wr(ASX_OFF_ACC, {24'h0, acc});
    wr(ASX_OFF_FILE_BASE + {1'b0, fa}, {24'h0, fv});
    wr(ASX_OFF_INSTR, {12'h0, o, d, fa, lit});
    m_acc = acc;
    m_f = fv;
    s = sub8(o == 4'h1 ? lit : fv, acc, o == 4'h3 ? ~m_c : 1'b0);
    case (o)
      4'h4: res = {fv[3:0], fv[7:4]};
      4'h6: res = acc ^ lit;
      4'h7: res = acc ^ fv;
      default: res = s[7:0];
    endcase
    if (o inside {4'h1, 4'h2, 4'h3}) begin
      m_c = s[9];
      m_dc = s[8];
    end
    if (o inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h7}) m_z = (res == 8'h00);
    if (o == 4'h5 && lit inside {[8'h05:8'h07]}) m_dir[lit - 8'h05] = acc;
    if (o == 4'h1 || o == 4'h6 || (o != 4'h5 && !d)) begin
      m_acc = res;
    end else if (o != 4'h5) begin
      m_f = res;
    end
    rdchk(ASX_OFF_ACC, {24'h0, m_acc});
    rdchk(ASX_OFF_FILE_BASE + {1'b0, fa}, {24'h0, m_f});
    rdchk(ASX_OFF_STATUS, {27'h0, 2'b11, m_z, m_dc, m_c});
    chk({8'h0, dir_c, dir_b, dir_a}, {8'h0, m_dir[2], m_dir[1], m_dir[0]});
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] rd;
    logic err;
    resetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(18));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdchk(ASX_OFF_STATUS, 32'h18);
    // Hand-written corners: equal operands, borrows, edge addresses
    do_op(4'h1, 1'b0, 7'h00, 8'h3C, 8'h3C, 8'h00);
    do_op(4'h1, 1'b0, 7'h00, 8'h10, 8'h11, 8'h00);
    do_op(4'h3, 1'b1, 7'h7F, 8'h00, 8'h05, 8'h05);
    do_op(4'h3, 1'b0, 7'h7F, 8'h00, 8'h04, 8'h05);
    do_op(4'h2, 1'b1, 7'h00, 8'h00, 8'h0F, 8'h10);
    do_op(4'h4, 1'b1, 7'h40, 8'h00, 8'h00, 8'hA5);
    do_op(4'h7, 1'b0, 7'h40, 8'h00, 8'h5A, 8'h5A);
    do_op(4'h6, 1'b0, 7'h00, 8'hFF, 8'hFF, 8'h00);
    for (i = 4; i < 9; i++) do_op(4'h5, 1'b0, 7'h00, 8'(i), 8'($urandom), 8'h00);
    do_op(4'h5, 1'b0, 7'h00, 8'h0D, 8'h77, 8'h00);
    // Random mix of every operation except sleep
    for (i = 0; i < 80; i++) begin
      op = 4'($urandom_range(7, 1));
      do_op(op, 1'($urandom_range(1)), 7'($urandom_range(127)),
            op == 4'h5 ? 8'($urandom_range(8, 4)) : 8'($urandom), 8'($urandom),
            8'($urandom));
    end
    // Unmapped address is flagged, mapped one is not
    apb(1'b0, 8'h1C, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, ASX_OFF_ACC, 32'h0, rd, err);
    chk({31'h0, err}, 32'h0);
    // Sleep entry, then an instruction that must be ignored
    chk(32'(n_clear), 32'h0);
    wr(ASX_OFF_INSTR, 32'h0008_0000);
    rdchk(ASX_OFF_STATUS, {26'h0, 3'b110, m_z, m_dc, m_c});
    chk(32'(n_clear), 32'h1);
    chk({31'h0, osc_stop}, 32'h1);
    rdchk(ASX_OFF_WDOG, {24'h0, ASX_WDOG_CLEAR});
    wr(ASX_OFF_INSTR, 32'h0006_00FF);
    rdchk(ASX_OFF_ACC, {24'h0, m_acc});
    // Only reset wakes the core
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk({31'h0, osc_stop}, 32'h0);
    rdchk(ASX_OFF_STATUS, 32'h18);
    finish_test();
  end
endmodule
